// ==== logic/gated_and_reload_timers.v ====
// Notes on behaviour
// - Counter mode counts event pin falling edges
// - Timer mode: sysclk or prescaled clock
// - Count only when run and gate allow
// - Run bit never clears the count
// - Timer 1 mirrors timer 0, gate input 1
// - Up overflow: flag, irq, reload, keep running
// - External falling edge reloads when enabled
// - Decrement enable: pin picks direction only
// - Down match reload: flag, irq, load ones
// - Clear select bit; run bit starts timer
// - External flag toggles on over/underflow
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gated_timers_consts.vh"

module gated_and_reload_timers (
   // Clock, enable, reset
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // Wishbone classic slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // External pins
   input wire timer0_event_pin_i,
   input wire timer1_event_pin_i,
   input wire ext_gate_input0_i,
   input wire ext_gate_input1_i,
   input wire timer_ext_pin_i,
   // Status outputs
   output reg external_toggle_flag_o,
   output reg irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] timer_control_reg;
reg [1:0] clock_scale_control;
reg [`TMR13_W-1:0] count0;
reg [`TMR13_W-1:0] count1;
reg run_control_n;
reg external_enable_n;
reg decrement_enable_n;
reg capture_reload_select_n;
reg [`TMR16_W-1:0] reload_pair;
reg [`TMR16_W-1:0] ar_count;
reg [`IRQ_W-1:0] irq_status;
reg [`IRQ_W-1:0] irq_mask;

reg [1:0] ev_pin_q;
reg ext_pin_q;

wire bus_req;
wire wr_en;
wire [1:0] ev_pins;
wire [1:0] gate_pins;
wire [1:0] ev_fall;
wire [1:0] t13_ovf;
wire presc_tick;
wire ext_fall;
wire ar_active;
wire ar_up;
wire ar_ovf;
wire ar_unf;
wire ar_reload_edge;
wire [`IRQ_W-1:0] irq_events;
wire [`IRQ_W-1:0] clear_bits;
wire [`IRQ_W-1:0] next_status;
wire st_hit;
wire ar_cnt_hit;
wire ar_wr_lo;
wire ar_wr_hi;
wire ar_wr;
wire ar_event;
wire [`TMR16_W-1:0] ar_loaded;
wire [`TMR16_W-1:0] ar_inc;
wire [`TMR16_W-1:0] ar_dec;
reg [31:0] next_dat;

// The ack term keeps a held request from being taken twice
assign bus_req = cyc_i & stb_i & ~ack_o;
assign wr_en = bus_req & we_i & ce_i;
assign ev_pins = {timer1_event_pin_i, timer0_event_pin_i};
assign gate_pins = {ext_gate_input1_i, ext_gate_input0_i};

////////////////////////////////////////////////////////////////////////////////
// Prescaler

// One prescaler serves both timers, so their ticks stay in step
count_step_gen u_step (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .ce_i(ce_i),
   .scale_i(clock_scale_control),
   .tick_o(presc_tick)
);

////////////////////////////////////////////////////////////////////////////////
// Pin edge detection (pins are synchronous to clk_i)

always @(posedge clk_i) begin
   if (rst_i) begin
      // Idle high after reset, so release shows no false edge
      ev_pin_q <= 2'h3;
      ext_pin_q <= 1'b1;
   end else if (ce_i) begin
      ev_pin_q <= ev_pins;
      ext_pin_q <= timer_ext_pin_i;
   end
end

assign ev_fall = ev_pin_q & ~ev_pins;
assign ext_fall = ext_pin_q & ~timer_ext_pin_i;

////////////////////////////////////////////////////////////////////////////////
// 13-bit timers 0 and 1

genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1) begin : g_t13
      wire [3:0] cfg;
      wire run_ok;
      wire step;
      wire [`TMR13_W-1:0] cur;
      wire wr_hit;
      wire wr_lo;
      wire wr_hi;
      wire wr_any;
      wire [`TMR13_W-1:0] loaded;
      // Timer 1 reuses the same logic with its own config nibble, event and gate pins, and count address
      assign cfg = timer_control_reg[gi*`CTL_T1_OFS +: 4];
      assign cur = (gi == 0) ? count0 : count1;
      // Gate input only matters when gate bit set
      assign run_ok = cfg[`CTL_RUN] & (~cfg[`CTL_GATE] | gate_pins[gi]);
      assign step = run_ok & (cfg[`CTL_CSEL] ? ev_fall[gi] :
         (cfg[`CTL_SYSCLK] ? 1'b1 : presc_tick));
      assign wr_hit = wr_en & (adr_i == ((gi == 0) ? `ADDR_COUNT0 : `ADDR_COUNT1));
      // Low and high count bytes load through their own lanes
      assign wr_lo = wr_hit & sel_i[0];
      assign wr_hi = wr_hit & sel_i[1];
      assign wr_any = wr_lo | wr_hi;
      assign loaded = {wr_hi ? dat_i[`TMR13_W-1:8] : cur[`TMR13_W-1:8],
         wr_lo ? dat_i[7:0] : cur[7:0]};
      // A count that software overwrites reports no wrap
      assign t13_ovf[gi] = step & (&cur) & ce_i & ~wr_any;
      if (gi == 0) begin : g_c0
         always @(posedge clk_i) begin
            if (rst_i) begin
               count0 <= {`TMR13_W{1'b0}};
            end else if (ce_i) begin
               // Software load wins over a same-cycle count step
               if (wr_any) begin
                  count0 <= loaded;
               end else if (step) begin
                  count0 <= count0 + 13'h0001;
               end
            end
         end
      end else begin : g_c1
         always @(posedge clk_i) begin
            if (rst_i) begin
               count1 <= {`TMR13_W{1'b0}};
            end else if (ce_i) begin
               if (wr_any) begin
                  count1 <= loaded;
               end else if (step) begin
                  count1 <= count1 + 13'h0001;
               end
            end
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// 16-bit auto-reload timer

// Capture mode is not built; with the select bit set the timer holds
assign ar_active = run_control_n & ~capture_reload_select_n;
assign ar_up = ~decrement_enable_n | timer_ext_pin_i;
// Up wrap restarts from the reload pair, down match from all ones
assign ar_ovf = ar_active & ar_up & (ar_count == `AR_ALL_ONES);
assign ar_unf = ar_active & ~ar_up & (ar_count == reload_pair);
// Direction pin edges never reload
assign ar_reload_edge = ar_active & external_enable_n & ~decrement_enable_n & ext_fall;
assign ar_inc = ar_count + 16'h0001;
assign ar_dec = ar_count - 16'h0001;

// Count bytes load through their own lanes, like the reload pair
assign ar_cnt_hit = wr_en & (adr_i == `ADDR_AR_COUNT);
assign ar_wr_lo = ar_cnt_hit & sel_i[0];
assign ar_wr_hi = ar_cnt_hit & sel_i[1];
assign ar_wr = ar_wr_lo | ar_wr_hi;
assign ar_loaded = {ar_wr_hi ? dat_i[`TMR16_W-1:8] : ar_count[`TMR16_W-1:8],
   ar_wr_lo ? dat_i[7:0] : ar_count[7:0]};
// Software load beats a same-cycle wrap: no flag, no toggle
assign ar_event = (ar_ovf | ar_unf) & ~ar_wr;

always @(posedge clk_i) begin
   if (rst_i) begin
      ar_count <= {`TMR16_W{1'b0}};
      external_toggle_flag_o <= 1'b0;
   end else if (ce_i) begin
      if (ar_wr) begin
         ar_count <= ar_loaded;
      end else if (ar_ovf || ar_reload_edge) begin
         ar_count <= reload_pair;
      end else if (ar_unf) begin
         ar_count <= `AR_ALL_ONES;
      end else if (ar_active) begin
         if (ar_up) begin
            ar_count <= ar_inc;
         end else begin
            ar_count <= ar_dec;
         end
      end
      // Reload edges alone leave the toggle flag as it is
      if (ar_event) begin
         external_toggle_flag_o <= ~external_toggle_flag_o;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status, mask and output

// Toggle flag deliberately absent from the event set
assign irq_events = {ar_event, t13_ovf};
assign st_hit = wr_en & (adr_i == `ADDR_IRQ_STATUS) & sel_i[0];
assign clear_bits = st_hit ? dat_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
// Set wins over write-one clear; nothing else clears
assign next_status = (irq_status & ~clear_bits) | irq_events;

always @(posedge clk_i) begin
   if (rst_i) begin
      irq_status <= {`IRQ_W{1'b0}};
      irq_o <= 1'b0;
   end else if (ce_i) begin
      irq_status <= next_status;
      // Follows the next status, so it rises with the flag
      irq_o <= |(next_status & irq_mask);
   end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

always @(posedge clk_i) begin
   if (rst_i) begin
      timer_control_reg <= `CTL_RESET;
      clock_scale_control <= `SCALE_RESET;
      run_control_n <= 1'b0;
      external_enable_n <= 1'b0;
      decrement_enable_n <= 1'b0;
      capture_reload_select_n <= 1'b0;
      reload_pair <= {`TMR16_W{1'b0}};
      irq_mask <= {`IRQ_W{1'b0}};
   end else if (wr_en) begin
      case (adr_i)
         `ADDR_CONTROL: begin
            if (sel_i[0]) begin
               timer_control_reg <= dat_i[7:0];
            end
         end
         `ADDR_SCALE: begin
            if (sel_i[0]) begin
               clock_scale_control <= dat_i[1:0];
            end
         end
         `ADDR_AR_CTRL: begin
            if (sel_i[0]) begin
               run_control_n <= dat_i[`AR_RUN];
               external_enable_n <= dat_i[`AR_EXEN];
               decrement_enable_n <= dat_i[`AR_DCEN];
               capture_reload_select_n <= dat_i[`AR_CPRL];
            end
         end
         // Either reload byte may be loaded alone
         `ADDR_AR_RELOAD: begin
            if (sel_i[0]) begin
               reload_pair[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
               reload_pair[15:8] <= dat_i[15:8];
            end
         end
         `ADDR_IRQ_MASK: begin
            if (sel_i[0]) begin
               irq_mask <= dat_i[`IRQ_W-1:0];
            end
         end
         default: begin
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read mux and acknowledge

always @* begin
   next_dat = 32'h00000000;
   case (adr_i)
      `ADDR_CONTROL: next_dat[7:0] = timer_control_reg;
      `ADDR_SCALE: next_dat[1:0] = clock_scale_control;
      `ADDR_COUNT0: next_dat[`TMR13_W-1:0] = count0;
      `ADDR_COUNT1: next_dat[`TMR13_W-1:0] = count1;
      // Toggle flag reads back as bit 4 of the auto-reload control word
      `ADDR_AR_CTRL: next_dat[4:0] = {external_toggle_flag_o, capture_reload_select_n,
         decrement_enable_n, external_enable_n, run_control_n};
      `ADDR_AR_RELOAD: next_dat[`TMR16_W-1:0] = reload_pair;
      `ADDR_AR_COUNT: next_dat[`TMR16_W-1:0] = ar_count;
      `ADDR_IRQ_STATUS: next_dat[`IRQ_W-1:0] = irq_status;
      `ADDR_IRQ_MASK: next_dat[`IRQ_W-1:0] = irq_mask;
      default: next_dat = 32'h00000000;
   endcase
end

// Unmapped addresses ack with zero data; one cycle latency
always @(posedge clk_i) begin
   if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
   end else if (ce_i) begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
         dat_o <= next_dat;
      end
   end
end

endmodule // gated_and_reload_timers

`default_nettype wire

// ==== include/gated_timers_consts.vh ====
`ifndef GATED_TIMERS_CONSTS_VH
`define GATED_TIMERS_CONSTS_VH

// Register byte addresses (word aligned)
`define ADDR_CONTROL 8'h00
`define ADDR_SCALE 8'h04
`define ADDR_COUNT0 8'h08
`define ADDR_COUNT1 8'h0c
`define ADDR_AR_CTRL 8'h10
`define ADDR_AR_RELOAD 8'h14
`define ADDR_AR_COUNT 8'h18
`define ADDR_IRQ_STATUS 8'h1c
`define ADDR_IRQ_MASK 8'h20

// Control register fields, timer 0 in bits 3:0, timer 1 in bits 7:4
`define CTL_RUN 0
`define CTL_GATE 1
`define CTL_CSEL 2
`define CTL_SYSCLK 3
`define CTL_T1_OFS 4
`define CTL_RESET 8'h00

// Clock scale field: 0 = /12, 1 = /4, 2 = /48, 3 = /8
`define SCALE_RESET 2'h0
`define DIV12 6'h0b
`define DIV4 6'h03
`define DIV48 6'h2f
`define DIV8 6'h07

// Auto-reload control fields
`define AR_RUN 0
`define AR_EXEN 1
`define AR_DCEN 2
`define AR_CPRL 3
`define AR_XFLAG 4
`define AR_RESET 5'h00

// Interrupt bits
`define IRQ_T0 0
`define IRQ_T1 1
`define IRQ_AR 2
`define IRQ_W 3

`define TMR13_W 13
`define TMR16_W 16
`define AR_ALL_ONES 16'hffff

`endif

// ==== logic/count_step_gen.v ====
`timescale 1ns/1ps
`default_nettype none
`include "gated_timers_consts.vh"

// Prescaled tick generator shared by both 13-bit timers
module count_step_gen (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // Selection
   input wire [1:0] scale_i,
   // Tick
   output reg tick_o
);

reg [5:0] div_cnt;
reg [5:0] div_top;

always @* begin
   case (scale_i)
      2'h0: div_top = `DIV12;
      2'h1: div_top = `DIV4;
      2'h2: div_top = `DIV48;
      default: div_top = `DIV8;
   endcase
end

always @(posedge clk_i) begin
   if (rst_i) begin
      div_cnt <= 6'h00;
      tick_o <= 1'b0;
   end else if (ce_i) begin
      // Wrap also when the field shrinks below current count
      if (div_cnt >= div_top) begin
         div_cnt <= 6'h00;
         tick_o <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 6'h01;
         tick_o <= 1'b0;
      end
   end
end

endmodule // count_step_gen

`default_nettype wire

// ==== tb/timers_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module timers_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic ack_o,
   input wire logic [31:0] dat_o,
   // Status
   input wire logic external_toggle_flag_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////
   sequence take_s;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence
   sequence answer_s;
      ack_o ##1 !ack_o;
   endsequence
   ack_resp_a: assert property (take_s |=> answer_s)
      else $error("bus request not answered by a single ack");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without a request");
   rdata_hold_a: assert property ($changed(dat_o) |-> ack_o && !we_i)
      else $error("read data moved outside a read");
   write_hold_a: assert property (ack_o && we_i |-> $stable(dat_o))
      else $error("read data moved on a write");
   upper_zero_a: assert property (dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   irq_sticky_a: assert property (irq_o && !(cyc_i && stb_i && we_i) |=> irq_o)
      else $error("interrupt dropped without a write");
   freeze_ce_a: assert property (!ce_i |=> $stable(external_toggle_flag_o) && $stable(irq_o))
      else $error("state moved while clock enable low");
   reset_clear_a: assert property ($fell(rst_i) |-> !irq_o && !ack_o && !external_toggle_flag_o)
      else $error("outputs not cleared by reset");
endmodule // timers_chk

bind gated_and_reload_timers timers_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .ack_o(ack_o), .dat_o(dat_o),
   .external_toggle_flag_o(external_toggle_flag_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb/ext_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pin levels move just after an edge, like a slow outside driver
module ext_pin_model (
   // Clock
   input wire logic clk_i,
   // Wanted levels: event0, event1, gate_control0, gate1, ext
   input wire logic [4:0] lvl_i,
   // Pins
   output logic [4:0] pin_o
);
   initial pin_o = 5'h13;
   always @(posedge clk_i) begin
      pin_o <= lvl_i;
   end
endmodule // ext_pin_model
`default_nettype wire

// ==== tb/gated_and_reload_timers_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gated_timers_consts.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module gated_and_reload_timers_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [3:0] lanes = 4'hf;
   logic [31:0] wd = 32'h0;
   logic [31:0] rv;
   logic [4:0] lvl = 5'h13;
   wire logic [4:0] pin;
   wire logic [31:0] rd;
   wire logic ack;
   wire logic xf;
   wire logic irq;
   int error_cnt = 0;
   int comparisons = 0;
   always #10 clk_i = ~clk_i;
   ext_pin_model u_pins (.clk_i(clk_i), .lvl_i(lvl), .pin_o(pin));
   gated_and_reload_timers u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wd), .dat_o(rd), .ack_o(ack), .timer0_event_pin_i(pin[0]),
      .timer1_event_pin_i(pin[1]), .ext_gate_input0_i(pin[2]),
      .ext_gate_input1_i(pin[3]), .timer_ext_pin_i(pin[4]),
      .external_toggle_flag_o(xf), .irq_o(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lanes;
      adr <= a;
      wd <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rv = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      @(posedge clk_i);
   endtask
   task automatic pulse(input int i);
      lvl[i] <= 1'b0;
      repeat (2) @(posedge clk_i);
      lvl[i] <= 1'b1;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic run0(input logic [31:0] ctl, input int n);
      wb(1'b1, `ADDR_COUNT0, 32'h0);
      wb(1'b1, `ADDR_CONTROL, ctl);
      repeat (n) @(posedge clk_i);
      wb(1'b1, `ADDR_CONTROL, 32'h0);
      wb(1'b0, `ADDR_COUNT0, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic reset_values();
      for (int a = 0; a <= 36; a += 4) begin
         wb(1'b0, 8'(a), 32'h0);
         `CHK(rv, 32'h0)
      end
      // Unmapped place swallows writes
      wb(1'b1, 8'h24, 32'hffff);
      wb(1'b0, 8'h24, 32'h0);
      `CHK(rv, 32'h0)
      // Low lane alone leaves the high count byte as it was
      wb(1'b1, `ADDR_COUNT0, 32'h1fff);
      lanes = 4'h1;
      wb(1'b1, `ADDR_COUNT0, 32'h0);
      lanes = 4'hf;
      wb(1'b0, `ADDR_COUNT0, 32'h0);
      `CHK(rv, 32'h1f00)
   endtask
   task automatic gate_and_events();
      wb(1'b1, `ADDR_COUNT0, 32'h100);
      wb(1'b1, `ADDR_CONTROL, 32'h3);
      pulse(0);
      wb(1'b0, `ADDR_COUNT0, 32'h0);
      `CHK(rv, 32'h100)
      wb(1'b1, `ADDR_CONTROL, 32'h5);
      repeat (3) pulse(0);
      wb(1'b0, `ADDR_COUNT0, 32'h0);
      `CHK(rv, 32'h103)
      wb(1'b1, `ADDR_CONTROL, 32'h0);
   endtask
   task automatic clock_choice();
      run0(32'h9, 100);
      `CHK(rv >= 100 && rv <= 106, 1'b1)
      wb(1'b1, `ADDR_SCALE, 32'h1);
      run0(32'h1, 400);
      `CHK(rv >= 98 && rv <= 104, 1'b1)
      wb(1'b1, `ADDR_SCALE, 32'h2);
      run0(32'h1, 4800);
      `CHK(rv >= 98 && rv <= 102, 1'b1)
      wb(1'b1, `ADDR_SCALE, 32'h3);
      run0(32'h1, 800);
      `CHK(rv >= 98 && rv <= 102, 1'b1)
      wb(1'b1, `ADDR_SCALE, 32'h0);
   endtask
   task automatic wrap_and_irq();
      wb(1'b1, `ADDR_IRQ_MASK, 32'h2);
      wb(1'b1, `ADDR_COUNT1, 32'h1fff);
      wb(1'b1, `ADDR_CONTROL, 32'h70);
      pulse(1);
      wb(1'b0, `ADDR_COUNT1, 32'h0);
      `CHK(rv, 32'h1fff)
      lvl[3] <= 1'b1;
      repeat (3) @(posedge clk_i);
      pulse(1);
      wb(1'b0, `ADDR_COUNT1, 32'h0);
      `CHK(rv, 32'h0)
      wb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      `CHK({rv, irq}, {32'h2, 1'b1})
      wb(1'b1, `ADDR_IRQ_MASK, 32'h0);
      `CHK(irq, 1'b0)
      wb(1'b1, `ADDR_IRQ_STATUS, 32'h2);
      wb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      `CHK(rv, 32'h0)
      wb(1'b1, `ADDR_CONTROL, 32'h0);
      lvl[3] <= 1'b0;
   endtask
   task automatic reload_up();
      logic [31:0] q;
      wb(1'b1, `ADDR_AR_RELOAD, 32'h1234);
      wb(1'b1, `ADDR_AR_COUNT, 32'hfff0);
      wb(1'b1, `ADDR_IRQ_MASK, 32'h4);
      wb(1'b1, `ADDR_AR_CTRL, 32'h1);
      repeat (30) @(posedge clk_i);
      wb(1'b0, `ADDR_AR_COUNT, 32'h0);
      `CHK(rv >= 32'h1234 && rv < 32'h1260, 1'b1)
      `CHK({xf, irq}, 2'b11)
      wb(1'b1, `ADDR_AR_CTRL, 32'h9);
      wb(1'b0, `ADDR_AR_COUNT, 32'h0);
      q = rv;
      repeat (5) @(posedge clk_i);
      wb(1'b0, `ADDR_AR_COUNT, 32'h0);
      `CHK(rv, q)
      wb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      `CHK(rv, 32'h4)
   endtask
   task automatic reload_edge();
      wb(1'b1, `ADDR_AR_COUNT, 32'h0);
      wb(1'b1, `ADDR_AR_CTRL, 32'h3);
      pulse(4);
      wb(1'b0, `ADDR_AR_COUNT, 32'h0);
      `CHK(rv >= 32'h1234 && rv < 32'h1260, 1'b1)
      `CHK(xf, 1'b1)
      wb(1'b1, `ADDR_AR_CTRL, 32'h0);
   endtask
   task automatic reload_down();
      lvl[4] <= 1'b0;
      wb(1'b1, `ADDR_IRQ_STATUS, 32'h4);
      wb(1'b1, `ADDR_AR_RELOAD, 32'h8);
      wb(1'b1, `ADDR_AR_COUNT, 32'h20);
      wb(1'b1, `ADDR_AR_CTRL, 32'h5);
      repeat (30) @(posedge clk_i);
      // Pause proves the frozen state holds its flags
      ce <= 1'b0;
      repeat (6) @(posedge clk_i);
      ce <= 1'b1;
      wb(1'b0, `ADDR_AR_COUNT, 32'h0);
      `CHK(rv >= 32'hffc0 && rv <= 32'hffff, 1'b1)
      `CHK(xf, 1'b0)
      wb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      `CHK({rv, irq}, {32'h4, 1'b1})
      wb(1'b1, `ADDR_IRQ_STATUS, 32'h4);
      wb(1'b1, `ADDR_AR_COUNT, 32'h100);
      lvl[4] <= 1'b1;
      repeat (4) @(posedge clk_i);
      lvl[4] <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, `ADDR_AR_COUNT, 32'h0);
      `CHK(rv >= 32'hf0 && rv <= 32'h110, 1'b1)
      wb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      `CHK(rv, 32'h0)
      wb(1'b1, `ADDR_AR_CTRL, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      reset_values();
      gate_and_events();
      clock_choice();
      wrap_and_irq();
      reload_up();
      reload_edge();
      reload_down();
      report_and_stop();
   end
   // Whole run needs about 6500 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      report_and_stop();
   end
endmodule // gated_and_reload_timers_tb_top
`default_nettype wire
